// >>> rtl/uart_reset_and_flow_status.sv
// per-channel uart register bank: reset states and flow character status
//
// Contract
// - the flow status register is all zeros whenever software flow control is off.
// - bit 3 is set when the last sent control character was a resume one and clears on read.
// - bit 2 is set when the last sent control character was a pause one and clears on read.
// - bit 1 is set when the last received control character was a resume one, read clears it.
// - bit 0 is set when the last received control character was a pause one, read clears it.
// - bits 7 to 4 of the flow status register are reserved and read as zero.
// - at power-up the divisor low byte is one and the high byte zero.
// - the hardware reset pin leaves both divisor bytes unchanged.
// - after reset the interrupt status register reads one, no interrupt pending.
// - after reset the line status register reads 0x60, both transmit stages empty.
// - after reset the scratch register holds all ones.
// - after reset all control, count, trigger, character and flow status registers are zero.
// - after reset the modem status change bits and upper bits are zero; upper bits show input levels two clocks later.
// - software flow control is off when the four select bits of the enhanced reg are zero.
`timescale 1ns/1ps
`include "uart_regs_defines.svh"

module uart_reset_and_flow_status
   import uart_regs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        por_n_i,
   input  wire reg_addr_t   addr_i,
   input  wire logic        rd_stb_i,
   input  wire logic        wr_stb_i,
   input  wire reg8_t       wdata_i,
   output reg8_t            rdata_o,
   input  wire reg8_t       receive_holding_i,
   output logic             rx_pop_o,
   output reg8_t            transmit_holding_o,
   output logic             tx_push_o,
   input  wire logic        core_update_i,
   input  wire reg8_t       int_status_i,
   input  wire reg8_t       line_status_i,
   input  wire reg8_t       tx_count_i,
   input  wire reg8_t       rx_count_i,
   input  wire logic        tx_resume_sent_i,
   input  wire logic        tx_pause_sent_i,
   input  wire logic        rx_resume_seen_i,
   input  wire logic        rx_pause_seen_i,
   input  wire logic        serial_bit_i,
   input  wire logic        infrared_bit_i,
   input  wire modem_bits_t modem_in_n_i,
   output reg8_t            divisor_low_o,
   output reg8_t            divisor_high_o,
   output reg8_t            enhanced_feature_o,
   output logic             tx_o,
   output logic             infrared_tx_out_o,
   output logic             rts_n_o,
   output logic             dtr_n_o
);

   // ****************************************************************
   // modem input synchronisers
   // ****************************************************************
   modem_bits_t modem_n_sync;
   modem_bits_t modem_level;
   modem_bits_t modem_prev_q;
   modem_bits_t modem_prev_d;

   bit_sync #(.WIDTH(4)) u_modem_sync (
      .clock_i     (clock_i),
      .arst_n_i    (arst_n_i),
      .async_i     (modem_in_n_i),
      .reset_val_i ('1),
      .sync_o      (modem_n_sync)
   );

   assign modem_level = ~modem_n_sync;

   // ****************************************************************
   // register state
   // ****************************************************************
   reg8_t int_enable_q,   int_enable_d;
   reg8_t fifo_ctrl_q,    fifo_ctrl_d;
   reg8_t int_status_q,   int_status_d;
   reg8_t line_ctrl_q,    line_ctrl_d;
   reg8_t modem_ctrl_q,   modem_ctrl_d;
   reg8_t line_status_q,  line_status_d;
   modem_bits_t modem_delta_q, modem_delta_d;
   reg8_t scratch_q,      scratch_d;
   reg8_t div_frac_q,     div_frac_d;
   reg8_t feature_q,      feature_d;
   reg8_t enhanced_q,     enhanced_d;
   reg8_t tx_count_q,     tx_count_d;
   reg8_t rx_count_q,     rx_count_d;
   reg8_t tx_trigger_q,   tx_trigger_d;
   reg8_t rx_trigger_q,   rx_trigger_d;
   reg8_t resume_one_q,   resume_one_d;
   reg8_t resume_two_q,   resume_two_d;
   reg8_t pause_one_q,    pause_one_d;
   reg8_t pause_two_q,    pause_two_d;
   reg8_t flow_status_q,  flow_status_d;
   reg8_t divisor_low_q,  divisor_low_d;
   reg8_t divisor_high_q, divisor_high_d;
   reg8_t rdata_q,        rdata_d;
   reg8_t tx_data_q,      tx_data_d;
   logic  tx_q,           tx_d;
   logic  infrared_tx_out_q,         infrared_tx_out_d;
   logic  rts_n_q,        rts_n_d;
   logic  dtr_n_q,        dtr_n_d;

   logic  wr_hit;
   logic  rd_hit;
   logic  sw_flow_on;
   logic  enh_open;
   logic  rd_flow;
   logic  rd_modem;

   assign wr_hit = wr_stb_i;
   assign rd_hit = rd_stb_i;
   assign sw_flow_on = |enhanced_q[3:0];
   assign enh_open   = enhanced_q[`EFR_ENH_BIT];
   assign rd_flow    = rd_hit && (addr_i == `ADDR_FLOW_STATUS);
   assign rd_modem   = rd_hit && (addr_i == `ADDR_MODEM_STAT);

   // ****************************************************************
   // next values of the channel registers
   // ****************************************************************
   always_comb begin
      int_enable_d  = int_enable_q;
      fifo_ctrl_d   = fifo_ctrl_q;
      int_status_d  = int_status_q;
      line_ctrl_d   = line_ctrl_q;
      modem_ctrl_d  = modem_ctrl_q;
      line_status_d = line_status_q;
      scratch_d     = scratch_q;
      div_frac_d    = div_frac_q;
      feature_d     = feature_q;
      enhanced_d    = enhanced_q;
      tx_count_d    = tx_count_q;
      rx_count_d    = rx_count_q;
      tx_trigger_d  = tx_trigger_q;
      rx_trigger_d  = rx_trigger_q;
      resume_one_d  = resume_one_q;
      resume_two_d  = resume_two_q;
      pause_one_d   = pause_one_q;
      pause_two_d   = pause_two_q;
      tx_data_d     = tx_data_q;
      // status words from the core are taken only on its update strobe,
      // so the reset values stand until the core reports otherwise
      if (core_update_i) begin
         int_status_d  = int_status_i;
         line_status_d = line_status_i;
         tx_count_d    = tx_count_i;
         rx_count_d    = rx_count_i;
      end
      if (wr_hit) begin
         case (addr_i)
            `ADDR_HOLDING:     tx_data_d    = wdata_i;
            // enhanced bits change only while the enhanced enable is open
            `ADDR_INT_ENABLE:  int_enable_d = enh_open ? wdata_i :
                                  ((int_enable_q & `IER_ENH_MASK) | (wdata_i & ~`IER_ENH_MASK));
            `ADDR_FIFO_INT:    fifo_ctrl_d  = enh_open ? wdata_i :
                                  ((fifo_ctrl_q & `FCR_ENH_MASK) | (wdata_i & ~`FCR_ENH_MASK));
            `ADDR_LINE_CTRL:   line_ctrl_d  = wdata_i;
            `ADDR_MODEM_CTRL:  modem_ctrl_d = enh_open ? wdata_i :
                                  ((modem_ctrl_q & `MCR_ENH_MASK) | (wdata_i & ~`MCR_ENH_MASK));
            `ADDR_SCRATCH:     scratch_d    = wdata_i;
            `ADDR_DIV_FRAC:    div_frac_d   = wdata_i;
            `ADDR_FEATURE:     feature_d    = wdata_i;
            `ADDR_ENHANCED:    enhanced_d   = wdata_i;
            `ADDR_TX_TRIGGER:  tx_trigger_d = wdata_i;
            `ADDR_RX_TRIGGER:  rx_trigger_d = wdata_i;
            `ADDR_RESUME_ONE:  resume_one_d = wdata_i;
            `ADDR_RESUME_TWO:  resume_two_d = wdata_i;
            `ADDR_PAUSE_ONE:   pause_one_d  = wdata_i;
            `ADDR_PAUSE_TWO:   pause_two_d  = wdata_i;
            default:           tx_data_d    = tx_data_q;
         endcase
      end
   end

   // ****************************************************************
   // flow character status and modem change bits
   // ****************************************************************
   always_comb begin
      flow_status_d = flow_status_q;
      if (rd_flow) begin
         flow_status_d = `RST_ZERO;
      end
      // events applied after the read clear
      if (tx_resume_sent_i) begin
         flow_status_d[`FLOW_TX_ON]  = 1'b1;
         flow_status_d[`FLOW_TX_OFF] = 1'b0;
      end
      if (tx_pause_sent_i) begin
         flow_status_d[`FLOW_TX_OFF] = 1'b1;
         flow_status_d[`FLOW_TX_ON]  = 1'b0;
      end
      if (rx_resume_seen_i) begin
         flow_status_d[`FLOW_RX_ON]  = 1'b1;
         flow_status_d[`FLOW_RX_OFF] = 1'b0;
      end
      if (rx_pause_seen_i) begin
         flow_status_d[`FLOW_RX_OFF] = 1'b1;
         flow_status_d[`FLOW_RX_ON]  = 1'b0;
      end
      if (!sw_flow_on) begin
         flow_status_d = `RST_ZERO;
      end
      flow_status_d[7:4] = 4'h0;

      // change seen wins over the read clear, as for the flow flags
      modem_prev_d  = modem_level;
      modem_delta_d = rd_modem ? 4'h0 : modem_delta_q;
      modem_delta_d = modem_delta_d | (modem_level ^ modem_prev_q);
   end

   // ****************************************************************
   // read data, holding strobes and pins
   // ****************************************************************
   always_comb begin
      rdata_d = `RST_ZERO;
      if (rd_hit) begin
         case (addr_i)
            `ADDR_HOLDING:     rdata_d = receive_holding_i;
            `ADDR_INT_ENABLE:  rdata_d = int_enable_q;
            `ADDR_FIFO_INT:    rdata_d = int_status_q;
            `ADDR_LINE_CTRL:   rdata_d = line_ctrl_q;
            `ADDR_MODEM_CTRL:  rdata_d = modem_ctrl_q;
            `ADDR_LINE_STAT:   rdata_d = line_status_q;
            `ADDR_MODEM_STAT:  rdata_d = {modem_level, modem_delta_q};
            `ADDR_SCRATCH:     rdata_d = scratch_q;
            `ADDR_DIV_LOW:     rdata_d = divisor_low_q;
            `ADDR_DIV_HIGH:    rdata_d = divisor_high_q;
            `ADDR_DIV_FRAC:    rdata_d = div_frac_q;
            `ADDR_FEATURE:     rdata_d = feature_q;
            `ADDR_ENHANCED:    rdata_d = enhanced_q;
            `ADDR_TX_COUNT:    rdata_d = tx_count_q;
            `ADDR_RX_COUNT:    rdata_d = rx_count_q;
            `ADDR_TX_TRIGGER:  rdata_d = tx_trigger_q;
            `ADDR_RX_TRIGGER:  rdata_d = rx_trigger_q;
            `ADDR_FLOW_STATUS: rdata_d = flow_status_q;
            default:           rdata_d = `RST_ZERO;
         endcase
      end
      tx_d    = serial_bit_i;
      infrared_tx_out_d  = infrared_bit_i;
      rts_n_d = ~modem_ctrl_d[`MCR_RTS_BIT];
      dtr_n_d = ~modem_ctrl_d[`MCR_DTR_BIT];
      // divisor writes are ignored while the reset pin is held
      divisor_low_d  = divisor_low_q;
      divisor_high_d = divisor_high_q;
      if (wr_hit && arst_n_i && (addr_i == `ADDR_DIV_LOW)) begin
         divisor_low_d = wdata_i;
      end
      if (wr_hit && arst_n_i && (addr_i == `ADDR_DIV_HIGH)) begin
         divisor_high_d = wdata_i;
      end
   end

   assign rx_pop_o  = rd_hit && (addr_i == `ADDR_HOLDING);
   assign tx_push_o = wr_hit && (addr_i == `ADDR_HOLDING);

   // ****************************************************************
   // registers on the reset pin
   // ****************************************************************
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         int_status_q  <= `RST_INT_STATUS;
         line_status_q <= `RST_LINE_STAT;
         scratch_q     <= `RST_SCRATCH;
         int_enable_q  <= `RST_ZERO;
         fifo_ctrl_q   <= `RST_ZERO;
         line_ctrl_q   <= `RST_ZERO;
         modem_ctrl_q  <= `RST_ZERO;
         div_frac_q    <= `RST_ZERO;
         feature_q     <= `RST_ZERO;
         enhanced_q    <= `RST_ZERO;
         tx_count_q    <= `RST_ZERO;
         rx_count_q    <= `RST_ZERO;
         tx_trigger_q  <= `RST_ZERO;
         rx_trigger_q  <= `RST_ZERO;
         resume_one_q  <= `RST_ZERO;
         resume_two_q  <= `RST_ZERO;
         pause_one_q   <= `RST_ZERO;
         pause_two_q   <= `RST_ZERO;
         flow_status_q <= `RST_ZERO;
         tx_data_q     <= `RST_ZERO;
         rdata_q       <= `RST_ZERO;
         modem_delta_q <= 4'h0;
         modem_prev_q  <= 4'h0;
         tx_q          <= 1'b1;
         rts_n_q       <= 1'b1;
         dtr_n_q       <= 1'b1;
         infrared_tx_out_q        <= 1'b0;
      end else begin
         int_status_q  <= int_status_d;
         line_status_q <= line_status_d;
         scratch_q     <= scratch_d;
         int_enable_q  <= int_enable_d;
         fifo_ctrl_q   <= fifo_ctrl_d;
         line_ctrl_q   <= line_ctrl_d;
         modem_ctrl_q  <= modem_ctrl_d;
         div_frac_q    <= div_frac_d;
         feature_q     <= feature_d;
         enhanced_q    <= enhanced_d;
         tx_count_q    <= tx_count_d;
         rx_count_q    <= rx_count_d;
         tx_trigger_q  <= tx_trigger_d;
         rx_trigger_q  <= rx_trigger_d;
         resume_one_q  <= resume_one_d;
         resume_two_q  <= resume_two_d;
         pause_one_q   <= pause_one_d;
         pause_two_q   <= pause_two_d;
         flow_status_q <= flow_status_d;
         tx_data_q     <= tx_data_d;
         rdata_q       <= rdata_d;
         modem_delta_q <= modem_delta_d;
         modem_prev_q  <= modem_prev_d;
         tx_q          <= tx_d;
         rts_n_q       <= rts_n_d;
         dtr_n_q       <= dtr_n_d;
         infrared_tx_out_q        <= infrared_tx_out_d;
      end
   end

   // ****************************************************************
   // divisor on power-up reset only
   // ****************************************************************
   // power-up divisor values
   // reset pin not in this process
   always_ff @(posedge clock_i or negedge por_n_i) begin
      if (!por_n_i) begin
         divisor_low_q  <= `RST_DIV_LOW;
         divisor_high_q <= `RST_DIV_HIGH;
      end else begin
         divisor_low_q  <= divisor_low_d;
         divisor_high_q <= divisor_high_d;
      end
   end

   assign rdata_o            = rdata_q;
   assign transmit_holding_o = tx_data_q;
   assign divisor_low_o      = divisor_low_q;
   assign divisor_high_o     = divisor_high_q;
   assign enhanced_feature_o = enhanced_q;
   assign tx_o               = tx_q;
   assign infrared_tx_out_o  = infrared_tx_out_q;
   assign rts_n_o            = rts_n_q;
   assign dtr_n_o            = dtr_n_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_flow_read;
      rd_flow && !tx_resume_sent_i && !tx_pause_sent_i
         && !rx_resume_seen_i && !rx_pause_seen_i;
   endsequence

   sequence s_resume_sent;
      sw_flow_on && tx_resume_sent_i && !tx_pause_sent_i;
   endsequence

   chk_flow_off_zero: assert property (!sw_flow_on |=> flow_status_q == 8'h00)
      else $error("flow status not zero with flow control off");
   chk_tx_resume_flag: assert property (s_resume_sent |=>
      flow_status_q[3] && !flow_status_q[2])
      else $error("sent resume flag wrong");
   chk_tx_pause_flag: assert property (sw_flow_on && tx_pause_sent_i && !tx_resume_sent_i
      |=> flow_status_q[2] && !flow_status_q[3])
      else $error("sent pause flag wrong");
   chk_rx_resume_flag: assert property (sw_flow_on && rx_resume_seen_i && !rx_pause_seen_i
      |=> flow_status_q[1] && !flow_status_q[0])
      else $error("received resume flag wrong");
   chk_rx_pause_flag: assert property (sw_flow_on && rx_pause_seen_i && !rx_resume_seen_i
      |=> flow_status_q[0] && !flow_status_q[1])
      else $error("received pause flag wrong");
   chk_flow_read_clear: assert property (s_flow_read |=> flow_status_q[3:0] == 4'h0)
      else $error("flow flags not cleared by read");
   chk_reserved_nibble: assert property (flow_status_q[7:4] == 4'h0)
      else $error("reserved flow bits set");
   // read data of a read one cycle later lags its strobe by one edge
   chk_event_beats_read: assert property (rd_flow ##0 s_resume_sent
      |=> flow_status_q[3] ##1 (rdata_q[3] || !$past(rd_flow)))
      else $error("flow event lost to read clear");
   chk_divisor_held: assert property (@(posedge clock_i) disable iff (!por_n_i)
      !arst_n_i |=> $stable(divisor_low_q) && $stable(divisor_high_q))
      else $error("divisor changed under reset pin");
   chk_reset_values: assert property ($rose(arst_n_i) |-> int_status_q == 8'h01
      && line_status_q == 8'h60 && scratch_q == 8'hff && enhanced_q == 8'h00)
      else $error("register reset value wrong");
   chk_reset_pins: assert property (@(posedge clock_i) disable iff (!por_n_i)
      !arst_n_i |-> tx_o && rts_n_o && dtr_n_o && !infrared_tx_out_o)
      else $error("pin reset level wrong");
   chk_modem_delta: assert property (rd_modem && (modem_level == modem_prev_q)
      |=> modem_delta_q == 4'h0)
      else $error("modem change bits not cleared by read");

endmodule // uart_reset_and_flow_status

// >>> include/uart_regs_defines.svh
// register offsets, reset values and field positions of one uart channel
`ifndef UART_REGS_DEFINES_SVH
`define UART_REGS_DEFINES_SVH

// ****************************************************************
// register offsets (5-bit index on the parallel bus)
// ****************************************************************
`define ADDR_HOLDING      5'h00
`define ADDR_INT_ENABLE   5'h01
`define ADDR_FIFO_INT     5'h02
`define ADDR_LINE_CTRL    5'h03
`define ADDR_MODEM_CTRL   5'h04
`define ADDR_LINE_STAT    5'h05
`define ADDR_MODEM_STAT   5'h06
`define ADDR_SCRATCH      5'h07
`define ADDR_DIV_LOW      5'h08
`define ADDR_DIV_HIGH     5'h09
`define ADDR_DIV_FRAC     5'h0a
`define ADDR_FEATURE      5'h0b
`define ADDR_ENHANCED     5'h0c
`define ADDR_TX_COUNT     5'h0d
`define ADDR_RX_COUNT     5'h0e
`define ADDR_TX_TRIGGER   5'h0f
`define ADDR_RX_TRIGGER   5'h10
`define ADDR_RESUME_ONE   5'h11
`define ADDR_RESUME_TWO   5'h12
`define ADDR_PAUSE_ONE    5'h13
`define ADDR_PAUSE_TWO    5'h14
`define ADDR_FLOW_STATUS  5'h15

// ****************************************************************
// reset values
// ****************************************************************
`define RST_ZERO          8'h00
`define RST_DIV_LOW       8'h01
`define RST_DIV_HIGH      8'h00
`define RST_INT_STATUS    8'h01
`define RST_LINE_STAT     8'h60
`define RST_SCRATCH       8'hff

// ****************************************************************
// field positions
// ****************************************************************
`define FLOW_TX_ON        3
`define FLOW_TX_OFF       2
`define FLOW_RX_ON        1
`define FLOW_RX_OFF       0
`define EFR_ENH_BIT       4
`define MCR_RTS_BIT       1
`define MCR_DTR_BIT       0
`define IER_ENH_MASK      8'he0
`define FCR_ENH_MASK      8'h30
`define MCR_ENH_MASK      8'hec
`define SYNC_STAGES       2

`endif

// >>> include/uart_regs_pkg.sv
// types shared by the uart channel register bank
package uart_regs_pkg;

   typedef logic [7:0] reg8_t;
   typedef logic [4:0] reg_addr_t;
   typedef logic [3:0] modem_bits_t;

endpackage

// >>> rtl/bit_sync.sv
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
`include "uart_regs_defines.svh"

module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   input  wire logic [WIDTH-1:0] reset_val_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage is read only by the second stage
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // bit_sync

// >>> bench/host_model.sv
// host processor model driving the channel register strobes
`timescale 1ns/1ps

module host_model
   import uart_regs_pkg::*;
(
   input  wire logic  clock_i,
   input  wire reg8_t rdata_i,
   output reg_addr_t  addr_o,
   output logic       rd_stb_o,
   output logic       wr_stb_o,
   output reg8_t      wdata_o
);
   initial begin
      addr_o   = 5'h1f;
      rd_stb_o = 1'b0;
      wr_stb_o = 1'b0;
      wdata_o  = 8'h00;
   end

   // ****************************************************************
   // one access: strobe held across the taking edge
   // ****************************************************************
   // released bus shows inverted values so stale data never looks valid
   task automatic access(input logic wr, input reg_addr_t a, input reg8_t d,
                         output reg8_t q);
      @(posedge clock_i);
      #1;
      addr_o   = a;
      wdata_o  = d;
      rd_stb_o = !wr;
      wr_stb_o = wr;
      @(posedge clock_i);
      #1;
      q        = rdata_i;
      rd_stb_o = 1'b0;
      wr_stb_o = 1'b0;
      addr_o   = ~a;
      wdata_o  = ~d;
   endtask
endmodule // host_model

// >>> bench/tb_top.sv
// self-checking bench for the channel register bank
`timescale 1ns/1ps
`include "uart_regs_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module tb_top
   import uart_regs_pkg::*;
;
   logic        clock_i, arst_n_i, por_n_i, rd_stb, wr_stb, core_update;
   logic        serial_bit, ir_bit, tx, infrared_tx_out, rts_n, dtr_n;
   logic [3:0]  ev;
   modem_bits_t modem_n;
   reg_addr_t   addr;
   reg8_t       wdata, rdata, stat, q, div_low, div_high;
   int          err_total = 0;
   int          compares = 0;
   reg_addr_t   ra[22] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
      5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13,
      5'h14, 5'h15, 5'h1f};
   reg8_t       rv[22] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'hff, 8'h01,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   host_model i_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
      .rd_stb_o(rd_stb), .wr_stb_o(wr_stb), .wdata_o(wdata));

   uart_reset_and_flow_status i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
      .por_n_i(por_n_i), .addr_i(addr), .rd_stb_i(rd_stb), .wr_stb_i(wr_stb),
      .wdata_i(wdata), .rdata_o(rdata), .receive_holding_i(stat), .rx_pop_o(),
      .transmit_holding_o(), .tx_push_o(), .core_update_i(core_update),
      .int_status_i(stat), .line_status_i(stat), .tx_count_i(stat), .rx_count_i(stat),
      .tx_resume_sent_i(ev[3]), .tx_pause_sent_i(ev[2]), .rx_resume_seen_i(ev[1]),
      .rx_pause_seen_i(ev[0]), .serial_bit_i(serial_bit), .infrared_bit_i(ir_bit),
      .modem_in_n_i(modem_n), .divisor_low_o(div_low), .divisor_high_o(div_high),
      .enhanced_feature_o(), .tx_o(tx), .infrared_tx_out_o(infrared_tx_out), .rts_n_o(rts_n),
      .dtr_n_o(dtr_n));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic finish_test();
      if (err_total == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic pulse(input logic [3:0] e);
      @(posedge clock_i);
      #1 ev = e;
      @(posedge clock_i);
      #1 ev = 4'h0;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      {arst_n_i, por_n_i, core_update, ev} = 7'h00;
      {serial_bit, ir_bit, modem_n} = 6'h1f;
      stat = 8'h3c;
      repeat (4) @(posedge clock_i);
      #1;
      `CHK({tx, rts_n, dtr_n, infrared_tx_out}, 4'he)
      {arst_n_i, por_n_i} = 2'b11;
      for (int i = 0; i < 22; i++) begin
         i_host.access(1'b0, ra[i], 8'h00, q);
         `CHK(q, rv[i])
      end
      i_host.access(1'b1, `ADDR_DIV_LOW, 8'h34, q);
      i_host.access(1'b1, `ADDR_SCRATCH, 8'h5a, q);
      // hardware reset alone must not touch the divisor
      @(posedge clock_i);
      #1 arst_n_i = 1'b0;
      @(posedge clock_i);
      #1;
      `CHK({tx, rts_n, dtr_n, infrared_tx_out}, 4'he)
      arst_n_i = 1'b1;
      `CHK({div_high, div_low}, 16'h0034)
      i_host.access(1'b0, `ADDR_SCRATCH, 8'h00, q);
      `CHK(q, 8'hff)
      // modem pins change: levels show in the upper nibble, changes below
      modem_n = 4'ha;
      repeat (3) @(posedge clock_i);
      i_host.access(1'b0, `ADDR_MODEM_STAT, 8'h00, q);
      `CHK(q, 8'h55)
      i_host.access(1'b0, `ADDR_MODEM_STAT, 8'h00, q);
      `CHK(q, 8'h50)
      pulse(4'h0);
      core_update = 1'b1;
      @(posedge clock_i);
      #1 core_update = 1'b0;
      i_host.access(1'b0, `ADDR_LINE_STAT, 8'h00, q);
      `CHK(q, 8'h3c)
      i_host.access(1'b1, `ADDR_ENHANCED, 8'h0f, q);
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         i_host.access(1'b0, `ADDR_FLOW_STATUS, 8'h00, q);
         `CHK(q, 8'h01 << i)
         i_host.access(1'b0, `ADDR_FLOW_STATUS, 8'h00, q);
         `CHK(q, 8'h00)
      end
      pulse(4'h8);
      pulse(4'h4);
      i_host.access(1'b0, `ADDR_FLOW_STATUS, 8'h00, q);
      `CHK(q, 8'h04)
      // event landing on the same edge as the clearing read
      fork
         i_host.access(1'b0, `ADDR_FLOW_STATUS, 8'h00, q);
         pulse(4'ha);
      join
      i_host.access(1'b0, `ADDR_FLOW_STATUS, 8'h00, q);
      `CHK(q, 8'h0a)
      pulse(4'h1);
      i_host.access(1'b1, `ADDR_ENHANCED, 8'h00, q);
      i_host.access(1'b0, `ADDR_FLOW_STATUS, 8'h00, q);
      `CHK(q, 8'h00)
      finish_test();
   end

   initial begin
      #200000;
      err_total++;
      finish_test();
   end
endmodule // tb_top
